// >>> src/dcsw_pkg.sv
// dcsw_pkg: constants and carriers for the drive command/state word block
// assumes: one 100 MHz clock, synchronous active-low reset
package dcsw_pkg;

	// ----------------------------------------------------------------
	// command word bit positions
	// ----------------------------------------------------------------
	localparam int CMD_OFF1      = 0;
	localparam int CMD_OFF2      = 1;
	localparam int CMD_OFF3      = 2;
	localparam int CMD_COAST     = 3;
	localparam int CMD_QSTOP     = 4;
	localparam int CMD_RAMP_USE  = 5;
	localparam int CMD_START     = 6;
	localparam int CMD_RESET     = 7;
	localparam int CMD_JOG1      = 8;
	localparam int CMD_JOG2      = 9;
	localparam int CMD_VALID     = 10;
	localparam int CMD_SLOW      = 11;
	localparam int CMD_CATCH     = 12;
	localparam int CMD_SET_LSB   = 13;
	localparam int CMD_SET_MSB   = 14;
	localparam int CMD_REVERSE   = 15;

	// ----------------------------------------------------------------
	// configuration codes and reset values
	// ----------------------------------------------------------------
	localparam logic [5:0]  RELAY_SEL_STOP0   = 6'h1F;  // relay function selection 31
	localparam logic [1:0]  PROFILE_STD       = 2'h1;   // standard profile selection 1
	localparam logic [15:0] CMD_RESET_VALUE   = 16'h0000;
	localparam logic [15:0] REF_HUNDRED_PCT   = 16'h4000; // 16384 = 100 %
	localparam logic [15:0] STATE_RESET_VALUE = 16'h0000;
	localparam logic [1:0]  SETUP_RESET_VALUE = 2'h0;

	// reversing source selection
	typedef enum logic [1:0] {
		DCSW_REV_DIGITAL = 2'b00,
		DCSW_REV_SERIAL  = 2'b01,
		DCSW_REV_OR      = 2'b10,
		DCSW_REV_AND     = 2'b11
	} dcsw_rev_e;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       warning;
		logic       speed_at_ref;
		logic       bus_control;
		logic       freq_in_limits;
		logic       freq_nonzero;
		logic       overload_autostart;
		logic       dc_volt_fault;
		logic       torque_exceeded;
		logic       thermal_exceeded;
		logic       tripped;
		logic       power_ready;
	} dcsw_drive_s;

	typedef struct packed {
		logic       ramp_stop;
		logic       coast_stop;
		logic       quick_stop;
		logic       freeze;
		logic       run_enable;
		logic       jog1;
		logic       jog2;
		logic       trim_down;
		logic       trim_up;
		logic       reverse;
		logic [1:0] setup;
		logic       setup_change;
		logic       fault_reset;
		logic       relay_on;
	} dcsw_cmd_s;

	typedef struct packed {
		logic [5:0] relay_sel;
		logic [1:0] profile;
		logic       multi_setup;
		logic       setups_linked;
		dcsw_rev_e  rev_source;
	} dcsw_cfg_s;

endpackage

// >>> src/dcsw_edge_det.sv
// dcsw_edge_det: rising edge detector with qualifying enable
// assumes: input synchronous to clk_sys
module dcsw_edge_det
	import dcsw_pkg::*;
(
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// sampled level
	input  wire logic sample_en,
	input  wire logic level_in,
	// result
	output logic      rise
);

	logic prev;

	// hold the last sampled level; reset to zero
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			prev <= 1'b0;
		end else if (sample_en) begin
			prev <= level_in;
		end
	end

	// edge only on an accepted sample
	assign rise = sample_en & level_in & ~prev;

endmodule

// >>> src/dcsw_core.sv
// dcsw_core: decodes the fieldbus command word and builds the state word
// Functional notes
// (R1) ignore whole command word unless valid bit set
// (R2) bit 0 low gives normal ramp stop
// (R3) bit 1 low coasts; bit 2 low quick-stops
// (R4) stop relay energised at 0 Hz if selected
// (R5) bit 3 low coasts; high permits start
// (R6) bit 4 low quick-stops; high permits start
// (R7) bit 5 low holds output frequency
// (R8) bit 6 low ramp-stops; high permits start
// (R9) fault reset only on bit 7 rising edge
// (R10) jogs honoured only with bit4 low, 0-3 high
// (R11) trim down/up; down wins when both set
// (R12) bits 13/14 select set-up when enabled
// (R13) bit 15 reverses only for serial/or/and source
// (R14) state bit 0: ready unless off or trip
// (R15) state bit 2: enable unless off or trip
// (R16) state bit 3 trip; no start until reset
// (R17) state bits 4,5 mirror command bits 1,2
// (R18) state bit 6 start-not-possible latch
// (R19) state bit 7 warning, bit 11 in operation
// (R20) state bit 8 speed equals reference
// (R21) state bit 9 bus control accepted
// (R22) state bits 10,12-15 report drive limits
// (R23) reference and actual value are 16384=100%
// (R24) state word refreshed on every telegram
// assumes: telegram strobe and drive status are synchronous to clk_sys
module dcsw_core
	import dcsw_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// telegram from the master
	input  wire logic        telegram_stb,
	input  wire logic [15:0] bus_command_word,
	input  wire logic [15:0] bus_speed_ref,
	// configuration
	input  wire dcsw_cfg_s   cfg,
	// drive state inputs
	input  wire dcsw_drive_s drive,
	input  wire logic [15:0] actual_output_value,
	input  wire logic        local_operator_panel,
	input  wire logic        start_signal,
	input  wire logic        drive_running,
	// decoded commands
	output dcsw_cmd_s        cmd,
	output logic [15:0]      speed_ref,
	// answer to the master
	output logic [15:0]      bus_state_word,
	output logic [15:0]      actual_value_word,
	output logic             state_valid
);

	// ------------------------------------------------------------
	// command latch
	// ------------------------------------------------------------
	logic [15:0] cw;
	logic        word_ok;
	logic        accept;

	assign word_ok = bus_command_word[CMD_VALID];
	assign accept  = telegram_stb & word_ok; // R1

	// keep the last valid word; invalid words leave commands and speed_ref as is but still get a state word answer
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cw <= CMD_RESET_VALUE;
		end else if (accept) begin
			cw <= bus_command_word; // R1 R24
		end
	end

	// ------------------------------------------------------------
	// reset edge detection
	// ------------------------------------------------------------
	logic reset_rise;

	dcsw_edge_det u_reset_edge (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.sample_en (accept),
		.level_in  (bus_command_word[CMD_RESET]),
		.rise      (reset_rise)
	);

	// ------------------------------------------------------------
	// trip latch and start inhibit
	// ------------------------------------------------------------
	logic trip_latch;
	logic next_trip_latch;
	logic start_block;
	logic next_start_block;
	logic power_on_done;

	// trip set wins over a reset edge in the same cycle
	assign next_trip_latch = drive.tripped | (trip_latch & ~reset_rise); // R9 R16

	// start-not-possible: set by reset ack, coast/quick-stop, power-on
	wire off_seq_clear = ~cw[CMD_OFF1] & cw[CMD_OFF2] & cw[CMD_OFF3]
		& cw[CMD_VALID];
	wire block_set     = reset_rise | ~cw[CMD_OFF2] | ~cw[CMD_OFF3]
		| ~power_on_done;
	assign next_start_block = (cfg.profile == PROFILE_STD)
		? (block_set | (start_block & ~off_seq_clear)) // R18
		: 1'b0;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			trip_latch    <= 1'b0;
			start_block   <= 1'b1;
			power_on_done <= 1'b0;
		end else begin
			trip_latch    <= next_trip_latch;
			start_block   <= next_start_block;
			power_on_done <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// stop decode
	// ------------------------------------------------------------
	wire off_any    = ~cw[CMD_OFF1] | ~cw[CMD_OFF2] | ~cw[CMD_OFF3];
	wire ramp_stop  = ~cw[CMD_OFF1] | ~cw[CMD_START];   // R2 R8
	wire coast_stop = ~cw[CMD_OFF2] | ~cw[CMD_COAST];   // R3 R5
	wire quick_stop = ~cw[CMD_OFF3] | ~cw[CMD_QSTOP];   // R3 R6
	wire run_ok     = ~ramp_stop & ~coast_stop & ~quick_stop
		& ~trip_latch & ~start_block;                   // R5 R6 R8 R16
	wire stop_req   = ~cw[CMD_OFF1] | ~cw[CMD_OFF2] | ~cw[CMD_OFF3]
		| ~cw[CMD_START];
	wire relay_on   = stop_req & ~drive.freq_nonzero
		& (cfg.relay_sel == RELAY_SEL_STOP0);          // R4

	// jog needs quick-stop bit low and bits 0..3 high
	wire jog_ok = ~cw[CMD_QSTOP] & (cw[3:0] == 4'hF);   // R10

	// reversing sources that honour the bus bit
	wire rev_bus = (cfg.rev_source == DCSW_REV_SERIAL)
		| (cfg.rev_source == DCSW_REV_OR)
		| (cfg.rev_source == DCSW_REV_AND);             // R13

	// set-up selection; lsb is bit 13, msb is bit 14
	wire [1:0] setup_req = {cw[CMD_SET_MSB], cw[CMD_SET_LSB]}; // R12
	wire       setup_ok  = cfg.multi_setup
		& (~drive_running | cfg.setups_linked);         // R12

	// ------------------------------------------------------------
	// command outputs
	// ------------------------------------------------------------
	dcsw_cmd_s next_cmd;
	logic [1:0] setup_q;

	always_comb begin
		next_cmd              = '0;
		next_cmd.ramp_stop    = ramp_stop;
		next_cmd.coast_stop   = coast_stop;
		next_cmd.quick_stop   = quick_stop;
		next_cmd.freeze       = ~cw[CMD_RAMP_USE];          // R7
		next_cmd.run_enable   = run_ok;
		next_cmd.jog1         = cw[CMD_JOG1] & jog_ok;      // R10
		next_cmd.jog2         = cw[CMD_JOG2] & jog_ok;      // R10
		next_cmd.trim_down    = cw[CMD_SLOW];               // R11
		next_cmd.trim_up      = cw[CMD_CATCH] & ~cw[CMD_SLOW]; // R11
		next_cmd.reverse      = cw[CMD_REVERSE] & rev_bus;  // R13
		next_cmd.setup        = setup_ok ? setup_req : setup_q; // R12
		next_cmd.setup_change = setup_ok & (setup_req != setup_q);
		next_cmd.fault_reset  = reset_rise;                 // R9
		next_cmd.relay_on     = relay_on;                   // R4
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cmd       <= '0;
			setup_q   <= SETUP_RESET_VALUE;
			speed_ref <= 16'h0000;
		end else begin
			cmd       <= next_cmd;
			setup_q   <= next_cmd.setup;
			if (accept) begin
				speed_ref <= bus_speed_ref; // R23
			end
		end
	end

	// ------------------------------------------------------------
	// state word assembly
	// ------------------------------------------------------------
	logic [15:0] next_state;
	wire         ctrl_ready = ~off_any & ~trip_latch;

	always_comb begin
		next_state     = STATE_RESET_VALUE;
		next_state[0]  = ctrl_ready;                        // R14
		next_state[1]  = ctrl_ready & drive.power_ready;
		next_state[2]  = ctrl_ready;                        // R15
		next_state[3]  = trip_latch;                        // R16
		next_state[4]  = cw[CMD_OFF2];                      // R17
		next_state[5]  = cw[CMD_OFF3];                      // R17
		next_state[6]  = start_block;                       // R18
		next_state[7]  = drive.warning;                     // R19
		next_state[8]  = drive.speed_at_ref;                // R20
		next_state[9]  = drive.bus_control & ~local_operator_panel; // R21
		next_state[10] = drive.freq_in_limits;              // R22
		next_state[11] = start_signal | drive.freq_nonzero; // R19
		next_state[12] = drive.overload_autostart;          // R22
		next_state[13] = drive.dc_volt_fault;               // R22
		next_state[14] = drive.torque_exceeded;             // R22
		next_state[15] = drive.thermal_exceeded;            // R22
	end

	// refresh the answer once per telegram
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			bus_state_word    <= STATE_RESET_VALUE;
			actual_value_word <= 16'h0000;
			state_valid       <= 1'b0;
		end else begin
			state_valid <= telegram_stb;
			if (telegram_stb) begin
				bus_state_word    <= next_state;          // R24
				actual_value_word <= actual_output_value; // R23
			end
		end
	end

endmodule

// >>> sim/dcsw_core_checker.sv
// dcsw_core_checker: port-level assertions for dcsw_core
// assumes: bound onto every dcsw_core instance, one clock domain
module dcsw_core_checker
	import dcsw_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// watched ports
	input  wire logic        telegram_stb,
	input  wire dcsw_cfg_s   cfg,
	input  wire dcsw_drive_s drive,
	input  wire logic [15:0] actual_output_value,
	input  wire dcsw_cmd_s   cmd,
	input  wire logic [15:0] bus_state_word,
	input  wire logic [15:0] actual_value_word,
	input  wire logic        state_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// -------------------------------------------------------------
	// telegram answer
	// -------------------------------------------------------------
	sequence s_answer;
		##1 state_valid;
	endsequence
	a_answer_follows: assert property (telegram_stb |-> s_answer)
		else $error("no answer after telegram");
	a_answer_cause: assert property (state_valid |-> $past(telegram_stb))
		else $error("answer without telegram");
	a_state_holds: assert property (!state_valid |-> $stable(bus_state_word))
		else $error("state word moved between telegrams");
	a_actual_copied: assert property (state_valid |->
		actual_value_word == $past(actual_output_value))
		else $error("actual value not copied");
	a_warn_copied: assert property (state_valid |->
		bus_state_word[7] == $past(drive.warning))
		else $error("warning bit wrong");

	// -------------------------------------------------------------
	// decoded commands
	// -------------------------------------------------------------
	a_trim_exclusive: assert property (!(cmd.trim_up && cmd.trim_down))
		else $error("both trims active");
	a_reset_pulse: assert property (cmd.fault_reset |=> !cmd.fault_reset)
		else $error("fault reset longer than one cycle");
	a_reverse_source: assert property ($rose(cmd.reverse) |->
		$past(cfg.rev_source) != DCSW_REV_DIGITAL)
		else $error("reverse with digital source");
	a_relay_select: assert property ($rose(cmd.relay_on) |->
		$past(cfg.relay_sel) == RELAY_SEL_STOP0)
		else $error("relay without selection");
endmodule

bind dcsw_core dcsw_core_checker i_chk (
	.clk_sys            (clk_sys),
	.rst_n              (rst_n),
	.telegram_stb       (telegram_stb),
	.cfg                (cfg),
	.drive              (drive),
	.actual_output_value(actual_output_value),
	.cmd                (cmd),
	.bus_state_word     (bus_state_word),
	.actual_value_word  (actual_value_word),
	.state_valid        (state_valid)
);

// >>> sim/dcsw_master_model.sv
// dcsw_master_model: fieldbus master sending command telegrams
// assumes: request inputs change at the falling edge
module dcsw_master_model
(
	// clock
	input  wire logic        clk_sys,
	// request from the bench
	input  wire logic        go,
	input  wire logic [15:0] cw_in,
	input  wire logic [15:0] ref_in,
	// telegram to the device
	output logic             telegram_stb,
	output logic [15:0]      bus_command_word,
	output logic [15:0]      bus_speed_ref
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle state at time zero
	initial begin
		telegram_stb = 1'b0;
		bus_command_word = 16'h0000;
		bus_speed_ref = 16'h0000;
	end
	// whole words per telegram; scrambled when idle
	always @(negedge clk_sys) begin
		telegram_stb <= go;
		bus_command_word <= go ? cw_in : ~bus_command_word;
		bus_speed_ref <= go ? ref_in : ~bus_speed_ref;
	end
endmodule

// >>> sim/drive_control_status_word_logic_tb_top.sv
// testbench for dcsw_core driven by the master model
// assumes: checker bound by its own file
module drive_control_status_word_logic_tb_top
	import dcsw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic             clk_sys, rst_n, go, pnl, st, run, telegram_stb, state_valid, trp, nsp;
	logic [1:0]       su;
	logic [15:0]      cwv, rfv, aov, bus_command_word, bus_speed_ref, speed_ref, bsw, avw;
	logic [15:0]      lastv, lastr, w;
	logic [15:0]      cor [8] = '{16'h7BEF, 16'hFBFF, 16'h0400, 16'h047F, 16'h04FF, 16'h04FF,
		16'h0406, 16'h647F};
	dcsw_cfg_s        cfg;
	dcsw_drive_s      drv;
	dcsw_cmd_s        cmd;
	int               err_total, comparisons, k, pulses;
	int               seed = 28931;

	dcsw_master_model i_mst (.clk_sys(clk_sys), .go(go), .cw_in(cwv), .ref_in(rfv),
		.telegram_stb(telegram_stb), .bus_command_word(bus_command_word),
		.bus_speed_ref(bus_speed_ref));
	dcsw_core i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .telegram_stb(telegram_stb),
		.bus_command_word(bus_command_word), .bus_speed_ref(bus_speed_ref), .cfg(cfg),
		.drive(drv), .actual_output_value(aov), .local_operator_panel(pnl),
		.start_signal(st), .drive_running(run), .cmd(cmd), .speed_ref(speed_ref),
		.bus_state_word(bsw), .actual_value_word(avw), .state_valid(state_valid));

	// clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// expected state word from the previous valid command, trip and start latch
	function automatic logic [15:0] exp_sw(input logic [15:0] p, input logic tr,
		input logic sb);
		logic r;
		r = &p[2:0] & ~tr;
		return {drv.thermal_exceeded, drv.torque_exceeded, drv.dc_volt_fault,
			drv.overload_autostart, st | drv.freq_nonzero, drv.freq_in_limits,
			drv.bus_control & ~pnl, drv.speed_at_ref, drv.warning, sb,
			p[2], p[1], tr, r, r & drv.power_ready, r};
	endfunction

	// expected jog, trim, reverse and freeze decode
	function automatic logic [15:0] exp_cmd(input logic [15:0] c);
		logic g;
		g = ~c[4] & (&c[3:0]);
		return {10'h000, c[8] & g, c[9] & g, c[11], c[12] & ~c[11],
			c[15] & (cfg.rev_source != DCSW_REV_DIGITAL), ~c[5]};
	endfunction

	// expected stop, run, relay and set-up decode
	function automatic logic [15:0] exp_run(input logic [15:0] c, input logic tr,
		input logic sb, input logic [1:0] s);
		logic rs, cs, qs;
		rs = ~c[0] | ~c[6];
		cs = ~c[1] | ~c[3];
		qs = ~c[2] | ~c[4];
		return {9'h000, rs, cs, qs, ~rs & ~cs & ~qs & ~tr & ~sb,
			~(&c[2:0] & c[6]) & ~drv.freq_nonzero
			& (cfg.relay_sel == RELAY_SEL_STOP0), s};
	endfunction

	// one telegram, then all answers compared
	task tel(input logic [15:0] t);
		int n, sc;
		logic [15:0] es;
		logic e, ok;
		nsp &= (cfg.profile == PROFILE_STD);
		trp = trp | drv.tripped;
		es = exp_sw(lastv, trp, nsp);
		e = t[10] & t[7] & ~lastv[7];
		ok = cfg.multi_setup & (~run | cfg.setups_linked);
		n = 0;
		sc = 0;
		pulses = 0;
		go <= 1'b1;
		cwv <= t;
		rfv <= 16'($random(seed));
		@(negedge clk_sys);
		go <= 1'b0;
		repeat (6) begin
			@(posedge clk_sys);
			#1;
			n += (state_valid === 1'b1);
			pulses += (cmd.fault_reset === 1'b1);
			sc += (cmd.setup_change === 1'b1);
		end
		chk(16'(n), 16'h0001);
		if (n != 1)
			give_verdict;
		chk(16'(pulses), {15'h0000, e});
		chk(16'(sc), {15'h0000, ok & t[10] & (t[14:13] != lastv[14:13])});
		chk(bsw, es);
		chk(avw, aov);
		trp = drv.tripped | (trp & ~e);
		nsp = nsp | e;
		if (t[10]) begin
			lastv = t;
			lastr = rfv;
			nsp = ~t[1] | ~t[2] | (nsp & t[0]);
		end
		nsp &= (cfg.profile == PROFILE_STD);
		if (ok)
			su = lastv[14:13];
		chk(speed_ref, lastr);
		chk({10'h000, cmd.jog1, cmd.jog2, cmd.trim_down, cmd.trim_up, cmd.reverse,
			cmd.freeze}, exp_cmd(lastv));
		chk({9'h000, cmd.ramp_stop, cmd.coast_stop, cmd.quick_stop, cmd.run_enable,
			cmd.relay_on, cmd.setup}, exp_run(lastv, trp, nsp, su));
		@(negedge clk_sys);
	endtask

	// main sequence
	initial begin
		{rst_n, go, cwv, rfv, aov, pnl, st, run, lastv, lastr, trp, su} = '0;
		cfg = '{6'h1F, PROFILE_STD, 1'b0, 1'b0, DCSW_REV_SERIAL};
		drv = '0;
		nsp = 1'b1;
		repeat (6) @(negedge clk_sys);
		rst_n = 1'b1;
		@(negedge clk_sys);
		for (k = 0; k < 60; k++) begin
			w = (k < 8) ? cor[k] : 16'($random(seed));
			drv = dcsw_drive_s'(11'($random(seed)));
			drv.tripped = 1'b0;
			aov = 16'($random(seed));
			pnl = 1'($random(seed));
			st = 1'($random(seed));
			{cfg.multi_setup, cfg.setups_linked, run} = 3'($random(seed));
			cfg.relay_sel = ($random(seed) & 1) ? RELAY_SEL_STOP0 : 6'h1E;
			if (w[10])
				cfg.rev_source = dcsw_rev_e'(2'($random(seed)));
			tel(w);
		end
		$display("corner and random telegrams done");
		drv.tripped = 1'b1;
		tel(16'h047F);
		tel(16'h047F);
		chk({15'h0000, bsw[3]}, 16'h0001);
		drv.tripped = 1'b0;
		tel(16'h047F);
		tel(16'h04FF);
		tel(16'h04FF);
		chk({15'h0000, bsw[3]}, 16'h0000);
		$display("trip and reset test done");
		cfg.profile = 2'h0;
		tel(16'h0400);
		chk({15'h0000, bsw[6]}, 16'h0000);
		$display("profile test done");
		give_verdict;
	end
endmodule
